/* design/clock_switch_failsafe_ctrl.sv */
// oscillator control registers, clock switch handling and fail-safe fallback
// How it works
// (RULE1) feedback multiplier is a 9-bit code in bits 8:0, multiplier is code plus two
// (RULE2) multiplier and tuning registers reset only at power-on, multiplier code 48
// (RULE3) 6-bit signed tuning code trims the fast RC in steps of about 0.375%
// (RULE4) switching and fail-safe monitor work only with the switch fuse at zero
// (RULE5) with switching off, next select is ignored and current follows the fuses
// (RULE6) with switching off, the switch request bit stays zero
// (RULE7) software unlocks, writes next select, unlocks, then sets the request bit
// (RULE8) request with next equal to current clears the request and aborts
// (RULE9) a valid switch clears the pll lock status and clock fail flag
// (RULE10) new source is started; wait start-up timer for crystals, lock for pll
// (RULE11) after ready, count ten new clock cycles before handing over
// (RULE12) on handover clear the request bit and copy next into current
// (RULE13) old source stops, except low-power rc if needed or secondary if enabled
// (RULE14) the processor keeps running during the whole switch
// (RULE15) software never switches directly between the two pll modes
// (RULE16) primary submode comes from fuses and software cannot change it
// (RULE17) with fail-safe monitor on, low-power rc runs except in sleep
// (RULE18) on clock failure raise a trap and fall back to the fast rc
// (RULE19) if pll was in use, fall back to fast rc with pll
// (RULE20) select codes: frc, frc pll, pri, pri pll, sec, low_power_rc_osc, frc/16, frc/n
// (RULE21) clock lock bit with monitor-select fuse one freezes clock and pll setup
// (RULE22) clock fail flag is set by the monitor; software reads or clears it
// (RULE23) control register bytes are writable only right after the key unlock
`timescale 1ns/1ps
module clock_switch_failsafe_ctrl
	import clk_switch_pkg::*;
(
	input  wire logic                  clk,
	input  wire logic                  rst,
	input  wire logic [ADDR_W-1:0]     addr,
	input  wire logic [DATA_W-1:0]     wdata,
	input  wire logic                  wr_en,
	input  wire logic                  rd_en,
	output logic      [DATA_W-1:0]     rdata_ff,
	input  wire logic                  switch_enable_fuse,
	input  wire logic                  monitor_select_fuse,
	input  wire logic [2:0]            initial_osc_select_fuse,
	input  wire logic [1:0]            primary_submode_fuse,
	input  wire logic                  ost_done,
	input  wire logic                  pll_lock,
	input  wire logic                  new_clk,
	input  wire logic                  osc_fail,
	input  wire logic                  wdt_en,
	input  wire logic                  sleep_mode,
	output logic      [2:0]            sys_clk_sel_ff,
	output logic      [SRC_W-1:0]      src_en_ff,
	output logic      [PLL_CODE_W-1:0] pll_multiplier_code_ff,
	output logic      [TUNE_W-1:0]     rc_tune_code_ff,
	output logic      [1:0]            primary_submode_ff,
	output logic                       fail_trap_ff
);
	// ****************************************
	// pin synchronisation
	// ****************************************
	logic [PIN_W-1:0] pin_s;
	logic             sw_fuse_s;
	logic             mon_fuse_s;
	logic [2:0]       init_osc_s;
	logic [1:0]       submode_s;
	logic             ost_s;
	logic             pll_lock_s;
	logic             new_clk_s;
	logic             fail_s;
	logic             wdt_s;
	logic             sleep_s;

	pin_sync #(.W(PIN_W)) u_sync (
		.clk         (clk),
		.rst         (rst),
		.pin_in      ({switch_enable_fuse, monitor_select_fuse, initial_osc_select_fuse,
			primary_submode_fuse, ost_done, pll_lock, new_clk, osc_fail, wdt_en,
			sleep_mode}),
		.pin_sync_ff (pin_s)
	);

	assign {sw_fuse_s, mon_fuse_s, init_osc_s, submode_s, ost_s, pll_lock_s, new_clk_s,
		fail_s, wdt_s, sleep_s} = pin_s;

	// ****************************************
	// control state
	// ****************************************
	logic [2:0] nxt_osc_ff;
	logic       clock_config_lock_ff;
	logic       lock_ff;
	logic       cf_ff;
	logic       secondary_osc_enable_ff;
	logic       switch_request_bit_ff;
	logic       go_ff;
	logic       key_seen_ff;
	logic       armed_ff;
	logic       fail_prev_ff;
	logic [1:0] init_cnt_ff;
	logic       init_done;
	logic       sw_en;
	logic       fail_safe_clock_monitor_en;
	logic       cfg_locked;
	logic       hi_wr;
	logic       lo_wr;
	logic       fail_evt;
	logic       set_req;
	logic [2:0] fallback;
	logic [DATA_W-1:0] ctrl_word;

	switch_if swi ();

	assign init_done  = (init_cnt_ff == INIT_CYCLES);
	assign sw_en      = !sw_fuse_s; // RULE4
	assign fail_safe_clock_monitor_en    = sw_en && !mon_fuse_s; // RULE4
	assign cfg_locked = clock_config_lock_ff && mon_fuse_s; // RULE21
	assign hi_wr      = wr_en && armed_ff && (addr == REG_CTRL_HI); // RULE23
	assign lo_wr      = wr_en && armed_ff && (addr == REG_CTRL_LO); // RULE23
	assign fail_evt   = fail_safe_clock_monitor_en && init_done && fail_s && !fail_prev_ff;
	assign set_req    = lo_wr && sw_en && !cfg_locked && wdata[SWITCH_REQUEST_BIT_BIT] && !swi.busy;
	assign fallback   = needs_pll(sys_clk_sel_ff) ? OSC_FRC_PLL : OSC_FRC; // RULE19 RULE20
	assign ctrl_word  = {1'b0, sys_clk_sel_ff, 1'b0, nxt_osc_ff, clock_config_lock_ff, 1'b0, lock_ff,
		1'b0, cf_ff, 1'b0, secondary_osc_enable_ff, switch_request_bit_ff};

	assign swi.go       = go_ff;
	assign swi.abort_sw = fail_evt;
	assign swi.cur_osc  = sys_clk_sel_ff;
	assign swi.nxt_osc  = nxt_osc_ff;
	assign swi.submode  = primary_submode_ff;
	assign swi.ost_done = ost_s;
	assign swi.pll_lock = pll_lock_s;
	assign swi.new_clk  = new_clk_s;

	osc_switch_seq u_seq (
		.clk (clk),
		.rst (rst),
		.sw  (swi.seq)
	);

	// fuses settle through the synchroniser before they are trusted
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			init_cnt_ff <= '0;
		else if (!init_done)
			init_cnt_ff <= init_cnt_ff + 2'h1;
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			primary_submode_ff <= SUBMODE_EC;
		else if (!init_done)
			primary_submode_ff <= submode_s; // RULE16
	end

	// ****************************************
	// key unlock
	// ****************************************
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			key_seen_ff <= 1'b0;
			armed_ff    <= 1'b0;
		end
		else if (wr_en || rd_en)
		begin
			key_seen_ff <= wr_en && (addr == REG_UNLOCK) && (wdata == UNLOCK_KEY_A); // RULE23
			armed_ff    <= key_seen_ff && wr_en && (addr == REG_UNLOCK)
				&& (wdata == UNLOCK_KEY_B); // RULE23
		end
	end

	// ****************************************
	// oscillator control fields
	// ****************************************
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			nxt_osc_ff <= OSC_FRC;
		else if (!init_done)
			nxt_osc_ff <= init_osc_s;
		else if (fail_evt)
			nxt_osc_ff <= fallback;
		else if (hi_wr && !cfg_locked) // RULE21
			nxt_osc_ff <= wdata[NXT_LSB +: 3];
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			clock_config_lock_ff <= 1'b0;
			secondary_osc_enable_ff <= 1'b0;
		end
		else if (lo_wr)
		begin
			if (!cfg_locked) // RULE21
				clock_config_lock_ff <= wdata[CLOCK_CONFIG_LOCK_BIT];
			secondary_osc_enable_ff <= wdata[SECONDARY_OSC_ENABLE_BIT];
		end
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			switch_request_bit_ff <= 1'b0;
			go_ff    <= 1'b0;
		end
		else
		begin
			go_ff <= set_req;
			if (!sw_en)
				switch_request_bit_ff <= 1'b0; // RULE6
			else if (swi.redundant || swi.done || fail_evt)
				switch_request_bit_ff <= 1'b0; // RULE8 RULE12
			else if (set_req)
				switch_request_bit_ff <= 1'b1;
		end
	end

	// the monitor set wins over a software clear in the same cycle
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			cf_ff <= 1'b0;
		else if (fail_evt)
			cf_ff <= 1'b1; // RULE22
		else if (swi.begin_sw)
			cf_ff <= 1'b0; // RULE9
		else if (lo_wr && !wdata[CF_BIT])
			cf_ff <= 1'b0; // RULE22
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			lock_ff <= 1'b0;
		else if (swi.begin_sw)
			lock_ff <= 1'b0; // RULE9
		else
			lock_ff <= pll_lock_s && src_en_ff[SRC_PLL];
	end

	// ****************************************
	// clock selection and fail-safe
	// ****************************************
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			sys_clk_sel_ff <= OSC_FRC;
		else if (!init_done || !sw_en)
			sys_clk_sel_ff <= init_osc_s; // RULE5
		else if (fail_evt)
			sys_clk_sel_ff <= fallback; // RULE18 RULE19
		else if (swi.done)
			sys_clk_sel_ff <= swi.target; // RULE12
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			fail_prev_ff <= 1'b0;
			fail_trap_ff <= 1'b0;
		end
		else
		begin
			fail_prev_ff <= fail_s;
			fail_trap_ff <= fail_evt; // RULE18
		end
	end

	// the outgoing source drops the cycle after the current select takes the target, two cycles after the sequencer stops holding it
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			src_en_ff <= '0;
		else
		begin
			src_en_ff <= src_need(sys_clk_sel_ff) // RULE13
				| (swi.busy ? src_need(swi.target) : '0) // RULE10
				| (secondary_osc_enable_ff ? src_need(OSC_SEC) : '0)
				| ((wdt_s || (fail_safe_clock_monitor_en && !sleep_s)) ? src_need(OSC_LOW_POWER_RC_OSC) : '0); // RULE17
		end
	end

	// ****************************************
	// pll and tuning registers
	// ****************************************
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			pll_multiplier_code_ff <= PLL_CODE_RST; // RULE2
			rc_tune_code_ff        <= TUNE_RST; // RULE2
		end
		else if (wr_en)
		begin
			if ((addr == REG_PLL_FBD) && !cfg_locked) // RULE21
				pll_multiplier_code_ff <= wdata[PLL_CODE_W-1:0]; // RULE1
			if (addr == REG_TUNE)
				rc_tune_code_ff <= wdata[TUNE_W-1:0]; // RULE3
		end
	end

	// ****************************************
	// read port, never stalls the processor
	// ****************************************
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			rdata_ff <= '0;
		else if (rd_en) // RULE14
		begin
			if ((addr == REG_CTRL_HI) || (addr == REG_CTRL_LO))
				rdata_ff <= ctrl_word;
			else if (addr == REG_PLL_FBD)
				rdata_ff <= {{(DATA_W-PLL_CODE_W){1'b0}}, pll_multiplier_code_ff};
			else if (addr == REG_TUNE)
				rdata_ff <= {{(DATA_W-TUNE_W){1'b0}}, rc_tune_code_ff};
			else
				rdata_ff <= '0;
		end
	end

	// ****************************************
	// checks
	// ****************************************
	chk_switch_request_bit_held_low: assert property (@(posedge clk) disable iff (rst) // RULE6
		!sw_en |=> !switch_request_bit_ff)
		else $error("request bit set while switching disabled");
	chk_cur_follows_fuse: assert property (@(posedge clk) disable iff (rst) // RULE5
		(init_done && !sw_en) |=> sys_clk_sel_ff == $past(init_osc_s))
		else $error("current select not from fuses");
	chk_fail_fallback: assert property (@(posedge clk) disable iff (rst) // RULE18
		fail_evt |=> fail_trap_ff && sys_clk_sel_ff == (needs_pll($past(sys_clk_sel_ff))
			? OSC_FRC_PLL : OSC_FRC))
		else $error("wrong fail-safe fallback");
	chk_cf_set: assert property (@(posedge clk) disable iff (rst) // RULE22
		fail_evt |=> cf_ff ##1 (cf_ff || $past(lo_wr) || $past(swi.begin_sw)))
		else $error("clock fail flag not set");
	chk_begin_clears: assert property (@(posedge clk) disable iff (rst) // RULE9
		(swi.begin_sw && !fail_evt) |=> !cf_ff && !lock_ff)
		else $error("switch start did not clear status");
	chk_cfg_frozen: assert property (@(posedge clk) disable iff (rst) // RULE21
		(cfg_locked && init_done && !fail_evt) |=> $stable(pll_multiplier_code_ff)
			&& $stable(nxt_osc_ff))
		else $error("locked configuration changed");
	chk_done_update: assert property (@(posedge clk) disable iff (rst) // RULE12
		(swi.done && sw_en && !fail_evt) |=> !switch_request_bit_ff && sys_clk_sel_ff == $past(swi.target))
		else $error("handover did not update status");
	chk_fail_safe_clock_monitor_low_power_rc_osc: assert property (@(posedge clk) disable iff (rst) // RULE17
		(fail_safe_clock_monitor_en && !sleep_s) |=> src_en_ff[SRC_LOW_POWER_RC_OSC])
		else $error("low-power rc stopped under monitor");
endmodule

/* design/osc_switch_seq.sv */
// clock switch sequencer: compare, wait ready, count new clock, hand over
`timescale 1ns/1ps
module osc_switch_seq
	import clk_switch_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	switch_if.seq    sw
);
	typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_WAIT_RDY = 2'b01, ST_COUNT = 2'b10} seq_st_t;
	seq_st_t    st_ff;
	logic [3:0] cnt_ff;
	logic       clk_prev_ff;
	logic       new_edge;
	logic       ready;

	assign new_edge = sw.new_clk && !clk_prev_ff;
	assign ready = (!needs_pll(sw.target) || sw.pll_lock)
		&& (!is_crystal(sw.target, sw.submode) || sw.ost_done);
	assign sw.busy = (st_ff != ST_IDLE);

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			clk_prev_ff <= 1'b0;
		else
			clk_prev_ff <= sw.new_clk;
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			st_ff        <= ST_IDLE;
			cnt_ff       <= '0;
			sw.target    <= OSC_FRC;
			sw.redundant <= 1'b0;
			sw.begin_sw  <= 1'b0;
			sw.done      <= 1'b0;
		end
		else
		begin
			sw.redundant <= 1'b0;
			sw.begin_sw  <= 1'b0;
			sw.done      <= 1'b0;
			if (sw.abort_sw)
				st_ff <= ST_IDLE;
			else
				case (st_ff)
					ST_IDLE:
						if (sw.go && (sw.nxt_osc == sw.cur_osc))
							sw.redundant <= 1'b1; // RULE8
						else if (sw.go)
						begin
							sw.begin_sw <= 1'b1; // RULE9
							sw.target   <= sw.nxt_osc;
							st_ff       <= ST_WAIT_RDY;
						end
					ST_WAIT_RDY:
						if (ready) // RULE10
						begin
							cnt_ff <= '0;
							st_ff  <= ST_COUNT;
						end
					ST_COUNT:
						if (new_edge && (cnt_ff == NEW_CLK_WAIT - 4'h1)) // RULE11
						begin
							sw.done <= 1'b1;
							st_ff   <= ST_IDLE;
						end
						else if (new_edge)
							cnt_ff <= cnt_ff + 4'h1;
					default:
						st_ff <= ST_IDLE;
				endcase
		end
	end

	chk_redundant_abort: assert property (@(posedge clk) disable iff (rst) // RULE8
		(st_ff == ST_IDLE && sw.go && !sw.abort_sw && sw.nxt_osc == sw.cur_osc)
		|=> sw.redundant && !sw.busy)
		else $error("redundant switch not aborted");
	chk_wait_ready: assert property (@(posedge clk) disable iff (rst) // RULE10
		(st_ff == ST_WAIT_RDY && !ready) |=> st_ff != ST_COUNT)
		else $error("left wait state before source ready");
	chk_count_ten: assert property (@(posedge clk) disable iff (rst) // RULE11
		sw.done |-> $past(st_ff) == ST_COUNT && $past(cnt_ff) == NEW_CLK_WAIT - 4'h1)
		else $error("handover before ten new clock cycles");
endmodule

/* design/pin_sync.sv */
// two-stage synchroniser for pin inputs
`timescale 1ns/1ps
module pin_sync
	import clk_switch_pkg::*;
#(
	parameter int W = PIN_W
)(
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic [W-1:0] pin_in,
	output logic      [W-1:0] pin_sync_ff
);
	logic [W-1:0] meta_ff;

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			meta_ff     <= '0;
			pin_sync_ff <= '0;
		end
		else
		begin
			meta_ff     <= pin_in;
			pin_sync_ff <= meta_ff;
		end
	end
endmodule

/* pkg/clk_switch_pkg.sv */
// constants, codes and helpers shared by the clock switch control block
package clk_switch_pkg;
	localparam int ADDR_W = 4;
	localparam int DATA_W = 16;
	localparam logic [ADDR_W-1:0] REG_CTRL_HI = 4'h0;
	localparam logic [ADDR_W-1:0] REG_CTRL_LO = 4'h1;
	localparam logic [ADDR_W-1:0] REG_PLL_FBD = 4'h2;
	localparam logic [ADDR_W-1:0] REG_TUNE    = 4'h3;
	localparam logic [ADDR_W-1:0] REG_UNLOCK  = 4'h4;
	// key values are arbitrary
	localparam logic [DATA_W-1:0] UNLOCK_KEY_A = 16'h00A5;
	localparam logic [DATA_W-1:0] UNLOCK_KEY_B = 16'h005A;
	localparam int CUR_LSB     = 12;
	localparam int NXT_LSB     = 8;
	localparam int CLOCK_CONFIG_LOCK_BIT = 7;
	localparam int LOCK_BIT    = 5;
	localparam int CF_BIT      = 3;
	localparam int SECONDARY_OSC_ENABLE_BIT = 1;
	localparam int SWITCH_REQUEST_BIT_BIT   = 0;
	localparam int PLL_CODE_W  = 9;
	localparam int TUNE_W      = 6;
	localparam logic [PLL_CODE_W-1:0] PLL_CODE_RST = 9'h030;
	localparam logic [TUNE_W-1:0]     TUNE_RST     = 6'h00;
	localparam logic [3:0] NEW_CLK_WAIT = 4'hA;
	localparam logic [1:0] INIT_CYCLES  = 2'h3;
	localparam logic [1:0] SUBMODE_EC   = 2'h0;
	localparam int SRC_FRC  = 0;
	localparam int SRC_PRI  = 1;
	localparam int SRC_SEC  = 2;
	localparam int SRC_LOW_POWER_RC_OSC = 3;
	localparam int SRC_PLL  = 4;
	localparam int SRC_W    = 5;
	localparam int PIN_W    = 13;
	typedef enum logic [2:0] {
		OSC_FRC = 3'h0, OSC_FRC_PLL = 3'h1, OSC_PRI = 3'h2, OSC_PRI_PLL = 3'h3,
		OSC_SEC = 3'h4, OSC_LOW_POWER_RC_OSC = 3'h5, OSC_FRC_DIV16 = 3'h6, OSC_FRC_DIVN = 3'h7
	} osc_sel_t;

	function automatic logic needs_pll(input logic [2:0] c);
		return (c == OSC_FRC_PLL) || (c == OSC_PRI_PLL);
	endfunction

	function automatic logic is_crystal(input logic [2:0] c, input logic [1:0] sub);
		return (((c == OSC_PRI) || (c == OSC_PRI_PLL)) && (sub != SUBMODE_EC)) || (c == OSC_SEC);
	endfunction

	function automatic logic [SRC_W-1:0] src_need(input logic [2:0] c);
		logic [SRC_W-1:0] m;
		m = '0;
		m[SRC_FRC]  = (c == OSC_FRC) || (c == OSC_FRC_PLL) || (c == OSC_FRC_DIV16)
			|| (c == OSC_FRC_DIVN);
		m[SRC_PRI]  = (c == OSC_PRI) || (c == OSC_PRI_PLL);
		m[SRC_SEC]  = (c == OSC_SEC);
		m[SRC_LOW_POWER_RC_OSC] = (c == OSC_LOW_POWER_RC_OSC);
		m[SRC_PLL]  = needs_pll(c);
		return m;
	endfunction
endpackage

/* pkg/switch_if.sv */
// signals between the register side and the switch sequencer
`timescale 1ns/1ps
interface switch_if;
	logic       go;
	logic       abort_sw;
	logic [2:0] cur_osc;
	logic [2:0] nxt_osc;
	logic [1:0] submode;
	logic       ost_done;
	logic       pll_lock;
	logic       new_clk;
	logic       redundant;
	logic       begin_sw;
	logic       done;
	logic       busy;
	logic [2:0] target;
	modport ctrl (output go, abort_sw, cur_osc, nxt_osc, submode, ost_done, pll_lock,
		new_clk, input redundant, begin_sw, done, busy, target);
	modport seq (input go, abort_sw, cur_osc, nxt_osc, submode, ost_done, pll_lock,
		new_clk, output redundant, begin_sw, done, busy, target);
endinterface

/* sim/testbench.sv */
// self-checking testbench for the clock switch and fail-safe control block
`timescale 1ns/1ps
module testbench;
	import clk_switch_pkg::*;
	// ************************************************************
	// signals and bookkeeping
	// ************************************************************
	logic                  clk = 1'b0;
	logic                  rst = 1'b1;
	logic [ADDR_W-1:0]     addr = '0;
	logic [DATA_W-1:0]     wdata = '0;
	logic                  wr_en = 1'b0;
	logic                  rd_en = 1'b0;
	logic [DATA_W-1:0]     rdata_ff;
	logic                  switch_enable_fuse = 1'b1;
	logic                  monitor_select_fuse = 1'b1;
	logic [2:0]            initial_osc_select_fuse = 3'h5;
	logic [1:0]            primary_submode_fuse = 2'h1;
	logic                  ost_done = 1'b0;
	logic                  pll_lock = 1'b0;
	logic                  new_clk = 1'b0;
	logic                  osc_fail = 1'b0;
	logic                  wdt_en = 1'b0;
	logic                  sleep_mode = 1'b0;
	logic [2:0]            sys_clk_sel_ff;
	logic [SRC_W-1:0]      src_en_ff;
	logic [PLL_CODE_W-1:0] pll_multiplier_code_ff;
	logic [TUNE_W-1:0]     rc_tune_code_ff;
	logic [1:0]            primary_submode_ff;
	logic                  fail_trap_ff;
	logic [2*DATA_W-1:0]   note_q[$];
	logic [2*DATA_W-1:0]   note;
	logic                  rd_seen = 1'b0;
	logic [15:0]           seed = 16'h0038;
	logic [DATA_W-1:0]     r;
	logic [DATA_W-1:0]     tune_tab[4];
	int                    fail_count = 0;
	int                    checked = 0;
	int                    trap_n;

	clock_switch_failsafe_ctrl uut (
		.clk                     (clk),
		.rst                     (rst),
		.addr                    (addr),
		.wdata                   (wdata),
		.wr_en                   (wr_en),
		.rd_en                   (rd_en),
		.rdata_ff                (rdata_ff),
		.switch_enable_fuse      (switch_enable_fuse),
		.monitor_select_fuse     (monitor_select_fuse),
		.initial_osc_select_fuse (initial_osc_select_fuse),
		.primary_submode_fuse    (primary_submode_fuse),
		.ost_done                (ost_done),
		.pll_lock                (pll_lock),
		.new_clk                 (new_clk),
		.osc_fail                (osc_fail),
		.wdt_en                  (wdt_en),
		.sleep_mode              (sleep_mode),
		.sys_clk_sel_ff          (sys_clk_sel_ff),
		.src_en_ff               (src_en_ff),
		.pll_multiplier_code_ff  (pll_multiplier_code_ff),
		.rc_tune_code_ff         (rc_tune_code_ff),
		.primary_submode_ff      (primary_submode_ff),
		.fail_trap_ff            (fail_trap_ff)
	);

	always #10 clk = ~clk;

	// ************************************************************
	// helpers
	// ************************************************************
	task automatic check(input string name, input logic [DATA_W-1:0] seen,
		input logic [DATA_W-1:0] exp);
		checked++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic final_report();
		if ((fail_count == 0) && (checked > 0))
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	function automatic logic [15:0] xs();
		seed = seed ^ (seed << 7);
		seed = seed ^ (seed >> 9);
		seed = seed ^ (seed << 8);
		return seed;
	endfunction

	function automatic logic [DATA_W-1:0] ctrl_w(input logic [2:0] c, input logic [2:0] n,
		input logic lk, input logic pl, input logic cf, input logic os);
		return {1'b0, c, 1'b0, n, lk, 1'b0, pl, 1'b0, cf, 2'b00, os};
	endfunction

	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		addr <= a;
		wdata <= d;
		wr_en <= 1'b1;
		rd_en <= 1'b0;
		@(posedge clk);
	endtask

	// the read note carries a mask so bits left open are not compared
	task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e,
		input logic [DATA_W-1:0] m);
		addr <= a;
		rd_en <= 1'b1;
		wr_en <= 1'b0;
		note_q.push_back({m, e});
		@(posedge clk);
	endtask

	task automatic idle(input int n);
		wr_en <= 1'b0;
		rd_en <= 1'b0;
		repeat (n) @(posedge clk);
	endtask

	task automatic unlock();
		wr(REG_UNLOCK, UNLOCK_KEY_A);
		wr(REG_UNLOCK, UNLOCK_KEY_B);
	endtask

	task automatic request(input logic [2:0] c, input logic [DATA_W-1:0] lo);
		unlock();
		wr(REG_CTRL_HI, {5'h00, c, 8'h00});
		unlock();
		wr(REG_CTRL_LO, lo);
		idle(1);
	endtask

	task automatic pulses(input int n);
		repeat (n)
		begin
			new_clk <= 1'b1;
			repeat (4) @(posedge clk);
			new_clk <= 1'b0;
			repeat (4) @(posedge clk);
		end
	endtask

	task automatic power_on(input logic sw, input logic ms, input logic [2:0] init);
		rst <= 1'b1;
		switch_enable_fuse <= sw;
		monitor_select_fuse <= ms;
		initial_osc_select_fuse <= init;
		ost_done <= 1'b0;
		pll_lock <= 1'b0;
		osc_fail <= 1'b0;
		idle(10);
		rst <= 1'b0;
		idle(4);
	endtask

	// ************************************************************
	// read monitor and watchdog
	// ************************************************************
	always @(posedge clk) rd_seen <= rd_en;

	always @(negedge clk)
	begin
		if (rd_seen === 1'b1)
		begin
			note = note_q.pop_front();
			check("rdata", rdata_ff & note[31:16], note[15:0] & note[31:16]);
		end
	end

	initial
	begin
		repeat (20000) @(posedge clk);
		fail_count++;
		final_report();
	end

	// ************************************************************
	// scenarios
	// ************************************************************
	initial
	begin
		@(posedge clk);
		power_on(1'b1, 1'b1, OSC_LOW_POWER_RC_OSC);
		check("sel_fuse", sys_clk_sel_ff, OSC_LOW_POWER_RC_OSC);
		check("pll_rst", pll_multiplier_code_ff, 9'h030);
		check("submode", primary_submode_ff, 2'h1);
		rd(REG_PLL_FBD, 16'h0030, 16'hFFFF);
		rd(REG_TUNE, 16'h0000, 16'hFFFF);
		rd(4'hF, 16'h0000, 16'hFFFF);
		wr(REG_PLL_FBD, 16'hFFFF);
		rd(REG_PLL_FBD, 16'h01FF, 16'hFFFF);
		idle(1);
		check("pll_port", pll_multiplier_code_ff, 9'h1FF);
		tune_tab[0] = 16'hFFE0;
		tune_tab[1] = 16'h001F;
		tune_tab[2] = xs();
		tune_tab[3] = xs();
		foreach (tune_tab[i])
		begin
			r = tune_tab[i];
			wr(REG_TUNE, r);
			rd(REG_TUNE, {10'h000, r[5:0]}, 16'hFFFF);
			idle(1);
			check("tune_port", rc_tune_code_ff, r[5:0]);
		end
		unlock();
		wr(REG_CTRL_LO, 16'h0081);
		idle(3);
		rd(REG_CTRL_LO, ctrl_w(OSC_LOW_POWER_RC_OSC, OSC_LOW_POWER_RC_OSC, 1'b1, 1'b0, 1'b0, 1'b0), 16'hFFFF);
		wr(REG_PLL_FBD, 16'h0005);
		rd(REG_PLL_FBD, 16'h01FF, 16'hFFFF);
		idle(20);
		check("sel_off", sys_clk_sel_ff, OSC_LOW_POWER_RC_OSC);

		power_on(1'b0, 1'b0, OSC_FRC);
		rd(REG_PLL_FBD, 16'h0030, 16'hFFFF);
		idle(1);
		check("low_power_rc_osc_on", src_en_ff[SRC_LOW_POWER_RC_OSC], 1'b1);
		wr(REG_CTRL_HI, 16'h0200);
		rd(REG_CTRL_HI, ctrl_w(OSC_FRC, OSC_FRC, 1'b0, 1'b0, 1'b0, 1'b0), 16'hFFFF);
		request(OSC_FRC, 16'h0001);
		idle(3);
		rd(REG_CTRL_HI, ctrl_w(OSC_FRC, OSC_FRC, 1'b0, 1'b0, 1'b0, 1'b0), 16'hFFFF);
		request(OSC_PRI_PLL, 16'h0001);
		idle(20);
		check("sel_wait", sys_clk_sel_ff, OSC_FRC);
		check("pri_start", src_en_ff[SRC_PRI], 1'b1);
		rd(REG_CTRL_LO, ctrl_w(OSC_FRC, OSC_PRI_PLL, 1'b0, 1'b0, 1'b0, 1'b1), 16'hFFFF);
		ost_done <= 1'b1;
		pll_lock <= 1'b1;
		idle(6);
		pulses(9);
		check("sel_nine", sys_clk_sel_ff, OSC_FRC);
		pulses(1);
		check("sel_ten", sys_clk_sel_ff, OSC_PRI_PLL);
		rd(REG_CTRL_HI, ctrl_w(OSC_PRI_PLL, OSC_PRI_PLL, 1'b0, 1'b1, 1'b0, 1'b0), 16'hFFFF);
		idle(2);
		check("src_after", src_en_ff, 5'h1A);
		osc_fail <= 1'b1;
		trap_n = 0;
		repeat (10)
		begin
			@(posedge clk);
			#1;
			if (fail_trap_ff === 1'b1)
				trap_n++;
		end
		check("trap_count", trap_n[15:0], 16'h0001);
		check("sel_fail", sys_clk_sel_ff, OSC_FRC_PLL);
		rd(REG_CTRL_HI, ctrl_w(OSC_FRC_PLL, OSC_FRC_PLL, 1'b0, 1'b0, 1'b1, 1'b0), 16'hFFDF);
		osc_fail <= 1'b0;
		request(OSC_FRC, 16'h0009);
		idle(2);
		rd(REG_CTRL_HI, 16'h0000, 16'h0008);
		idle(2);
		pulses(10);
		check("sel_back", sys_clk_sel_ff, OSC_FRC);
		idle(3);
		final_report();
	end
endmodule
